// ==== hw/adc_cfg_pkg.sv ====
package adc_cfg_pkg;

  // Register map
  localparam logic [7:0] ANALOG_CFG_ADDR  = 8'h0b;
  localparam logic [7:0] DIGITAL_CFG_ADDR = 8'h0c;
  localparam logic [7:0] CLOCK_CFG1_ADDR  = 8'h0d;

  localparam logic [7:0] ANALOG_CFG_RESET  = 8'h60;
  localparam logic [7:0] DIGITAL_CFG_RESET = 8'h3c;
  localparam logic [7:0] CLOCK_CFG1_RESET  = 8'h08;

  // Analog configuration fields
  localparam int NEG_PUMP_BIT  = 7;
  localparam int HIGH_RES_BIT  = 6;
  localparam int RSVD_ONE_BIT  = 5;
  localparam int REF_LEVEL_BIT = 4;
  localparam int INT_REF_BIT   = 3;
  localparam int COMP_LVL_LSB  = 0;

  // Digital configuration fields
  localparam int TIMEOUT_EN_BIT = 7;
  localparam int CHECK_COV_BIT  = 6;
  localparam int DONE_DLY_LSB   = 4;
  localparam int FLOAT_DLY_LSB  = 2;
  localparam int CONST_LEN_BIT  = 1;
  localparam int CHECK_EN_BIT   = 0;

  // Clock configuration 1 fields
  localparam int CLK_SRC_BIT = 7;
  localparam int CLK_DIV_LSB = 1;

  // Output delay timing
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int DELAY_BASE_PS   = 6000;
  localparam int DELAY_STEP_PS   = 2000;

  // Frame lengths with constant frame length selected
  localparam logic [2:0] FIXED_WORDS_FOUR_CH = 3'h6;
  localparam logic [2:0] FIXED_WORDS_TWO_CH  = 3'h4;

  // Comparator high threshold in tenths of a percent; low side is 1000 minus it
  localparam logic [9:0] PERMILLE_FULL = 10'h3e8;
  localparam logic [9:0] COMP_HIGH_TABLE [8] = '{
    10'h3b6, 10'h39d, 10'h384, 10'h36b, 10'h352, 10'h320, 10'h2ee, 10'h2bc
  };

  // Least delay rounds up to whole clock cycles
  function automatic logic [2:0] delay_cycles(input logic [1:0] sel);
    int ps;
    ps = DELAY_BASE_PS + DELAY_STEP_PS * int'(sel);
    return 3'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  endfunction : delay_cycles

endpackage : adc_cfg_pkg

// ==== hw/adc_system_config_regs.sv ====
module adc_system_config_regs
  import adc_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Register access from the serial host port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic       cmd_check_fail,
  output logic      [7:0] reg_rdata,
  output logic            reg_rd_valid,
  output logic            cmd_rejected,
  // Frame timing events
  input  wire logic       frame_start,
  input  wire logic       last_bit_shifted,
  output logic            transfer_complete,
  output logic            serial_out_drive,
  // Frame composition
  input  wire logic       four_channel_part,
  input  wire logic [3:0] converter_enable,
  output logic      [2:0] frame_words,
  output logic            check_word_enable,
  output logic            check_coverage_select,
  // Analog controls
  output logic            neg_pump_enable,
  output logic            high_res_select,
  output logic            ref_level_select,
  output logic            internal_ref_enable,
  output logic      [2:0] fault_comparator_level,
  output logic      [9:0] comp_high_permille,
  output logic      [9:0] comp_low_permille,
  output logic            comp_low_ref_pump,
  // Digital and clock controls
  output logic            timeout_counter_enable,
  output logic            clock_source_select,
  output logic      [2:0] clock_divider
);

  // Register file state
  logic [7:0] analog_q, analog_d;
  logic [7:0] digital_q, digital_d;
  logic [7:0] clock1_q, clock1_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rd_valid_q, rd_valid_d;
  logic       rejected_q, rejected_d;
  logic       accept;

  // A failed check code only matters once the check word is in use
  assign accept = !(digital_q[CHECK_EN_BIT] && cmd_check_fail);

  always_comb begin
    analog_d   = analog_q;
    digital_d  = digital_q;
    clock1_d   = clock1_q;
    rdata_d    = rdata_q;
    rd_valid_d = 1'b0;
    rejected_d = 1'b0;
    if ((reg_wr_en || reg_rd_en) && !accept) begin
      rejected_d = 1'b1;
    end
    if (reg_wr_en && accept) begin
      unique case (reg_addr)
        ANALOG_CFG_ADDR: begin
          // Bit 5 stores what the host writes; keeping it one is the host's job
          analog_d = reg_wdata;
        end
        DIGITAL_CFG_ADDR: begin
          digital_d = reg_wdata;
        end
        CLOCK_CFG1_ADDR: begin
          clock1_d = reg_wdata;
        end
        default: begin
        end
      endcase
    end
    if (reg_rd_en && accept) begin
      rd_valid_d = 1'b1;
      unique case (reg_addr)
        ANALOG_CFG_ADDR:  rdata_d = analog_q;
        DIGITAL_CFG_ADDR: rdata_d = digital_q;
        CLOCK_CFG1_ADDR:  rdata_d = clock1_q;
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      analog_q   <= ANALOG_CFG_RESET;
      digital_q  <= DIGITAL_CFG_RESET;
      clock1_q   <= CLOCK_CFG1_RESET;
      rdata_q    <= 8'h00;
      rd_valid_q <= 1'b0;
      rejected_q <= 1'b0;
    end else begin
      analog_q   <= analog_d;
      digital_q  <= digital_d;
      clock1_q   <= clock1_d;
      rdata_q    <= rdata_d;
      rd_valid_q <= rd_valid_d;
      rejected_q <= rejected_d;
    end
  end

  // Delay counters for completion and output float
  logic [2:0] done_cnt_q, done_cnt_d;
  logic [2:0] float_cnt_q, float_cnt_d;
  logic       complete_q, complete_d;
  logic       drive_q, drive_d;

  // Delay settings are sampled at the last bit, so a change mid-wait waits for the next frame
  always_comb begin
    done_cnt_d  = done_cnt_q;
    float_cnt_d = float_cnt_q;
    complete_d  = 1'b0;
    drive_d     = drive_q;
    if (done_cnt_q != 3'h0) begin
      done_cnt_d = done_cnt_q - 3'h1;
      if (done_cnt_q == 3'h1) begin
        complete_d = 1'b1;
      end
    end
    if (float_cnt_q != 3'h0) begin
      float_cnt_d = float_cnt_q - 3'h1;
      if (float_cnt_q == 3'h1) begin
        drive_d = 1'b0;
      end
    end
    if (last_bit_shifted) begin
      done_cnt_d  = delay_cycles(digital_q[DONE_DLY_LSB +: 2]);
      float_cnt_d = delay_cycles(digital_q[FLOAT_DLY_LSB +: 2]);
    end
    // A new frame takes the pin back even if the float wait is still running
    if (frame_start) begin
      drive_d     = 1'b1;
      float_cnt_d = 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      done_cnt_q  <= 3'h0;
      float_cnt_q <= 3'h0;
      complete_q  <= 1'b0;
      drive_q     <= 1'b0;
    end else begin
      done_cnt_q  <= done_cnt_d;
      float_cnt_q <= float_cnt_d;
      complete_q  <= complete_d;
      drive_q     <= drive_d;
    end
  end

  // Decoded controls, registered so every output leaves a flip-flop
  logic [2:0] words_q, words_d;
  logic [9:0] high_q, high_d;
  logic [9:0] low_q, low_d;

  always_comb begin
    words_d = 3'h1;
    if (digital_q[CONST_LEN_BIT]) begin
      words_d = four_channel_part ? FIXED_WORDS_FOUR_CH : FIXED_WORDS_TWO_CH;
    end else begin
      // Status word plus one per enabled converter (converters 2 and 3 counted on four-channel parts only) plus optional check word
      words_d = 3'h1 + 3'(converter_enable[0]) + 3'(converter_enable[1])
              + 3'(converter_enable[2] && four_channel_part)
              + 3'(converter_enable[3] && four_channel_part)
              + 3'(digital_q[CHECK_EN_BIT]);
    end
    high_d = COMP_HIGH_TABLE[analog_q[COMP_LVL_LSB +: 3]];
    low_d  = PERMILLE_FULL - high_d;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      words_q <= 3'h1;
      high_q  <= COMP_HIGH_TABLE[0];
      low_q   <= PERMILLE_FULL - COMP_HIGH_TABLE[0];
    end else begin
      words_q <= words_d;
      high_q  <= high_d;
      low_q   <= low_d;
    end
  end

  assign reg_rdata              = rdata_q;
  assign reg_rd_valid           = rd_valid_q;
  assign cmd_rejected           = rejected_q;
  assign transfer_complete      = complete_q;
  assign serial_out_drive       = drive_q;
  assign frame_words            = words_q;
  assign check_word_enable      = digital_q[CHECK_EN_BIT];
  assign check_coverage_select  = digital_q[CHECK_COV_BIT];
  assign neg_pump_enable        = analog_q[NEG_PUMP_BIT];
  assign high_res_select        = analog_q[HIGH_RES_BIT];
  // The level only matters while the internal reference is connected
  assign ref_level_select       = analog_q[REF_LEVEL_BIT];
  assign internal_ref_enable    = analog_q[INT_REF_BIT];
  assign fault_comparator_level = analog_q[COMP_LVL_LSB +: 3];
  assign comp_high_permille     = high_q;
  assign comp_low_permille      = low_q;
  assign comp_low_ref_pump      = analog_q[NEG_PUMP_BIT];
  // Disabling the watchdog needs a device reset from the host afterwards
  assign timeout_counter_enable = digital_q[TIMEOUT_EN_BIT];
  assign clock_source_select    = clock1_q[CLK_SRC_BIT];
  assign clock_divider          = clock1_q[CLK_DIV_LSB +: 3];

endmodule : adc_system_config_regs

// ==== sim/adc_cfg_chk.sv ====
module adc_cfg_chk (
  // Host port
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr_en,
  input wire logic       reg_rd_en,
  input wire logic       cmd_check_fail,
  input wire logic       reg_rd_valid,
  input wire logic       cmd_rejected,
  // Frame and fields
  input wire logic       frame_start,
  input wire logic       last_bit_shifted,
  input wire logic       transfer_complete,
  input wire logic       serial_out_drive,
  input wire logic       check_word_enable,
  input wire logic       neg_pump_enable,
  input wire logic       high_res_select,
  input wire logic [9:0] comp_high_permille,
  input wire logic [9:0] comp_low_permille,
  input wire logic       comp_low_ref_pump
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire bad = check_word_enable && cmd_check_fail;
  wire wd7 = reg_wdata[7];
  a_read_answer: assert property (reg_rd_en && !bad |=> reg_rd_valid)
    else $error("read not answered");
  a_check_refuse: assert property ((reg_rd_en || reg_wr_en) && bad |=> cmd_rejected && !reg_rd_valid)
    else $error("bad command not refused");
  a_refused_keep: assert property (reg_wr_en && bad |=> $stable(neg_pump_enable))
    else $error("refused write took effect");
  a_pump_write: assert property (reg_wr_en && reg_addr == 8'h0b && !bad |=> neg_pump_enable == $past(wd7))
    else $error("pump bit not written");
  a_low_ref: assert property (comp_low_ref_pump == neg_pump_enable)
    else $error("low reference wrong");
  a_thresh_sum: assert property (comp_high_permille + comp_low_permille == 10'h3e8)
    else $error("thresholds not symmetric");
  // The pulse registers on the edge the count reaches zero and is sampled one edge later, so the longest setting shows at the fourth edge
  a_done_time: assert property (last_bit_shifted ##1 !last_bit_shifted [*2] |-> ##[1:2] transfer_complete)
    else $error("completion late");
  a_float_time: assert property (last_bit_shifted ##1 !(last_bit_shifted || frame_start) [*2] |-> ##[1:2] !serial_out_drive)
    else $error("output not floated");
  a_drive_start: assert property (frame_start |=> serial_out_drive)
    else $error("output not driven");
  a_reset_vals: assert property ($rose(nrst) |-> high_res_select && !neg_pump_enable)
    else $error("reset value wrong");
  c_reject: cover property (cmd_rejected);
  c_done: cover property (transfer_complete);
  c_read: cover property (reg_rd_valid);
endmodule : adc_cfg_chk

// ==== sim/host_port_model.sv ====
module host_port_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic            cmd_check_fail,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rd_valid,
  input  wire logic       cmd_rejected
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    cmd_check_fail = 1'b0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      input logic bad, output logic [7:0] q, output logic [1:0] st);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = wr;
    reg_rd_en = !wr;
    cmd_check_fail = bad;
    @(posedge clk);
    #1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    cmd_check_fail = 1'b0;
    // Released lines flip so stale data is never mistaken for a request
    reg_addr = ~a;
    reg_wdata = ~d;
    q = reg_rdata;
    st = {cmd_rejected, reg_rd_valid};
  endtask : xfer
endmodule : host_port_model

// ==== sim/tb.sv ====
module tb;
  import adc_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, nrst, frame_start, last_bit_shifted, four_channel_part;
  logic [3:0] converter_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic       reg_wr_en, reg_rd_en, cmd_check_fail, reg_rd_valid, cmd_rejected;
  logic       transfer_complete, serial_out_drive, check_word_enable, check_coverage_select;
  logic       neg_pump_enable, high_res_select, ref_level_select, internal_ref_enable;
  logic       comp_low_ref_pump, timeout_counter_enable, clock_source_select;
  logic [2:0] frame_words, fault_comparator_level, clock_divider;
  logic [9:0] comp_high_permille, comp_low_permille;
  logic [1:0] st;
  int         mismatches, n_checks;
  adc_system_config_regs uut (.*);
  host_port_model host (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Decoded outputs are registered once more after the register itself
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, 1'b0, q, st);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, 1'b0, q, st);
    chk({st, q}, {2'b01, e});
  endtask : rd
  task automatic do_reset();
    @(posedge clk);
    #1 nrst = 1'b0;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
  endtask : do_reset
  task automatic t_reset();
    rd(8'h0b, 8'h60);
    rd(8'h0c, 8'h3c);
    rd(8'h0d, 8'h08);
    rd(8'h0a, 8'h00);
    chk(high_res_select, 1'b1);
  endtask : t_reset
  task automatic t_analog();
    logic [9:0] hi [8] = '{10'h3b6, 10'h39d, 10'h384, 10'h36b, 10'h352, 10'h320, 10'h2ee, 10'h2bc};
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {i[0], i[1], 1'b1, i[2], ~i[0], i[2:0]};
      wr(8'h0b, d);
      chk({neg_pump_enable, high_res_select, ref_level_select, internal_ref_enable,
           fault_comparator_level}, {d[7:6], d[4:0]});
      chk(comp_low_ref_pump, d[7]);
      tick();
      chk(comp_high_permille, hi[i]);
      chk(comp_low_permille, 10'h3e8 - hi[i]);
      rd(8'h0b, d);
    end
  endtask : t_analog
  task automatic t_delay();
    int k;
    for (int s = 0; s < 4; s++) begin
      wr(8'h0c, {2'b11, s[1:0], s[1:0], 2'b00});
      chk({timeout_counter_enable, check_coverage_select}, 2'b11);
      frame_start = 1'b1;
      @(posedge clk);
      #1 frame_start = 1'b0;
      chk(serial_out_drive, 1'b1);
      last_bit_shifted = 1'b1;
      @(posedge clk);
      #1 last_bit_shifted = 1'b0;
      k = 0;
      while (transfer_complete !== 1'b1 && k < 8) begin
        @(posedge clk);
        #1 k++;
      end
      chk(k, 2 + (s == 3));
      chk(serial_out_drive, 1'b0);
    end
    wr(8'h0c, 8'h3c);
    do_reset();
    rd(8'h0c, 8'h3c);
    rd(8'h0b, 8'h60);
  endtask : t_delay
  task automatic t_frame();
    wr(8'h0c, 8'h3e);
    tick();
    chk(frame_words, 3'h6);
    four_channel_part = 1'b0;
    @(posedge clk);
    #1 chk(frame_words, 3'h4);
    converter_enable = 4'h7;
    wr(8'h0c, 8'h3c);
    tick();
    chk(frame_words, 3'h3);
  endtask : t_frame
  task automatic t_check();
    wr(8'h0c, 8'h3d);
    chk(check_word_enable, 1'b1);
    host.xfer(1'b1, 8'h0b, 8'h80, 1'b1, q, st);
    chk(st, 2'b10);
    host.xfer(1'b0, 8'h0b, 8'h00, 1'b1, q, st);
    chk(st, 2'b10);
    rd(8'h0b, 8'h60);
    wr(8'h0d, 8'h86);
    chk({clock_source_select, clock_divider}, 4'hb);
    rd(8'h0d, 8'h86);
  endtask : t_check
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    nrst = 1'b0;
    frame_start = 1'b0;
    last_bit_shifted = 1'b0;
    four_channel_part = 1'b1;
    converter_enable = 4'h0;
    mismatches = 0;
    n_checks = 0;
    do_reset();
    t_reset();
    t_analog();
    t_delay();
    t_frame();
    t_check();
    final_report();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    mismatches++;
    final_report();
  end
endmodule : tb
bind adc_system_config_regs adc_cfg_chk chk_i (.*);
